// ---- i2caf_map.vh ----
// Register map and constants of the I2C slave address filter and baud generator.
// Assumes a 32-bit APB slave; offsets are byte addresses.
`ifndef I2CAF_MAP_VH
`define I2CAF_MAP_VH
// Register byte offsets
`define I2CAF_CTRL_OFF 12'h000
`define I2CAF_ADDR_OFF 12'h004
`define I2CAF_MASK_OFF 12'h008
`define I2CAF_BAUD_OFF 12'h00C
`define I2CAF_STAT_OFF 12'h010
`define I2CAF_RXA_OFF 12'h014
// Control register fields
`define I2CAF_CTRL_EN 0
`define I2CAF_CTRL_A10M 10
`define I2CAF_CTRL_PMEN 11
`define I2CAF_CTRL_GENERAL_CALL_ENABLE 7
`define I2CAF_CTRL_MASTER 1
`define I2CAF_CTRL_WMASK 32'h0000_0C83
// Status register fields
`define I2CAF_STAT_MATCH 0
`define I2CAF_STAT_GCALL 1
`define I2CAF_STAT_UPPER 2
`define I2CAF_STAT_SCL 3
// Address patterns
`define I2CAF_GCALL_ADDR 7'h00
`define I2CAF_TEN_UPPER 5'h1E
`define I2CAF_RES_HI 5'h1F
`define I2CAF_RES_LO 4'h0
// Instruction clock is the oscillator halved
`define I2CAF_FCY_DIV 2
`endif

// ---- i2caf_baud.v ----
// Serial clock generator: each half-period lasts reload plus one instruction-clock ticks.
// Assumes pclk is the oscillator; instruction ticks are pclk divided by two.
`timescale 1ns/1ps
module i2caf_baud #(
   parameter WIDTH = 9
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Control
   input wire run,
   input wire [WIDTH-1:0] reload,
   // Output
   output reg scl_level
);
   reg [WIDTH-1:0] count;
   reg fcy_phase;
   wire fcy_tick;
   assign fcy_tick = fcy_phase;
   // Fcy = Fosc/2, no doze or multiplier
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fcy_phase <= 1'b0;
      end else begin
         fcy_phase <= ~fcy_phase;
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= {WIDTH{1'b0}};
         scl_level <= 1'b1;
      end else if (fcy_tick) begin
         // Idle on the next tick, so stopping can cut a half-period short
         if (!run) begin
            count <= {WIDTH{1'b0}};
            scl_level <= 1'b1;
         end else if (count >= reload) begin
            count <= {WIDTH{1'b0}};
            scl_level <= ~scl_level;
         end else begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ---- i2caf_top.v ----
// Slave address filter with mask, reserved-address rejection and baud generator, APB registers.
// Assumes the shift logic presents each received address byte with a one-cycle strobe.
//
// Function
// - A mask bit set to one makes that received address bit don't-care in 7-bit and 10-bit addressing.
// - The mask is applied only while the platform-management enable bit 11 of the control register is clear.
// - Reserved addresses are never acknowledged even if the mask would widen the match onto them.
// - Addresses 0000001, 0000010, 0000011, 00001xx and 11111xx with any R/W, and 0000000 with R/W one, never match.
// - The general call address with R/W zero is acknowledged only when general call enable is one.
// - Pattern 11110xx matches only as the upper byte of a 10-bit address in 10-bit mode.
// - Baud reload counts use an instruction clock equal to the oscillator divided by two.
`timescale 1ns/1ps
`include "i2caf_map.vh"
module i2caf_top #(
   parameter BRG_WIDTH = 9
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Received address byte from the shifter
   input wire addr_valid,
   input wire [7:0] addr_byte,
   input wire addr_second,
   // Filter result
   output reg addr_ack,
   output reg addr_nack,
   // Master serial clock
   output reg scl_out
);
   reg [31:0] bus_control_reg;
   reg [9:0] slave_addr_reg;
   reg [9:0] slave_address_mask_reg;
   reg [BRG_WIDTH-1:0] baud_reload_reg;
   reg [7:0] last_byte;
   reg st_match;
   reg st_gcall;
   reg st_upper;
   reg upper_ok;
   wire scl_level;
   wire platform_mgmt_enable;
   wire general_call_enable;
   wire ten_bit;
   wire [9:0] eff_mask;
   wire [6:0] rx7;
   wire rw;
   wire is_res;
   wire is_gc;
   wire is_upper;
   wire hit7;
   wire hit_up;
   wire hit_lo;
   wire hit;
   wire wr_en;
   wire rd_en;

   assign platform_mgmt_enable = bus_control_reg[`I2CAF_CTRL_PMEN];
   assign general_call_enable = bus_control_reg[`I2CAF_CTRL_GENERAL_CALL_ENABLE];
   assign ten_bit = bus_control_reg[`I2CAF_CTRL_A10M];
   // Mask disabled while platform management is on
   assign eff_mask = platform_mgmt_enable ? 10'h000 : slave_address_mask_reg;
   assign rx7 = addr_byte[7:1];
   assign rw = addr_byte[0];

   // Reserved-pattern decode, shared by filter and status
   function reserved7;
      input [6:0] a;
      input r;
      begin
         reserved7 = ((a[6:3] == `I2CAF_RES_LO) && (a[2:0] != 3'h0)) ||
                     (a[6:2] == `I2CAF_RES_HI) ||
                     ((a == `I2CAF_GCALL_ADDR) && r);
      end
   endfunction

   // Masked compare
   function masked_eq;
      input [9:0] a;
      input [9:0] b;
      input [9:0] m;
      begin
         masked_eq = ((a ^ b) & ~m) == 10'h000;
      end
   endfunction

   assign is_res = reserved7(rx7, rw);
   assign is_gc = (rx7 == `I2CAF_GCALL_ADDR) && !rw;
   assign is_upper = (rx7[6:2] == `I2CAF_TEN_UPPER);
   assign hit7 = !ten_bit && !is_upper &&
                 masked_eq({3'h0, rx7}, {3'h0, slave_addr_reg[6:0]}, eff_mask);
   assign hit_up = ten_bit && is_upper &&
                   masked_eq({8'h00, rx7[1:0]}, {8'h00, slave_addr_reg[9:8]}, {8'h00, eff_mask[9:8]});
   assign hit_lo = ten_bit && upper_ok &&
                   masked_eq({2'h0, addr_byte}, {2'h0, slave_addr_reg[7:0]}, eff_mask & 10'h0FF);
   // Reserved codes beat any masked hit; second byte is raw data
   assign hit = addr_second ? hit_lo :
                (is_gc ? general_call_enable : (!is_res && (hit7 || hit_up)));

   // Filter outputs, one-cycle pulses
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_ack <= 1'b0;
         addr_nack <= 1'b0;
         upper_ok <= 1'b0;
         st_match <= 1'b0;
         st_gcall <= 1'b0;
         st_upper <= 1'b0;
         last_byte <= 8'h00;
      end else begin
         addr_ack <= addr_valid && bus_control_reg[`I2CAF_CTRL_EN] && hit;
         addr_nack <= addr_valid && !(bus_control_reg[`I2CAF_CTRL_EN] && hit);
         if (addr_valid) begin
            last_byte <= addr_byte;
            st_match <= bus_control_reg[`I2CAF_CTRL_EN] && hit;
            st_gcall <= !addr_second && is_gc && general_call_enable;
            st_upper <= !addr_second && hit_up && !is_res;
            if (addr_second) begin
               upper_ok <= 1'b0;
            end else begin
               upper_ok <= hit_up && !is_res;
            end
         end
      end
   end

   // APB: zero wait states, unmapped reads zero, no error
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_control_reg <= 32'h0000_0000;
         slave_addr_reg <= 10'h000;
         slave_address_mask_reg <= 10'h000;
         baud_reload_reg <= {BRG_WIDTH{1'b0}};
      end else if (wr_en) begin
         case (paddr)
            `I2CAF_CTRL_OFF: begin
               bus_control_reg <= pwdata & `I2CAF_CTRL_WMASK;
            end
            `I2CAF_ADDR_OFF: begin
               slave_addr_reg <= pwdata[9:0];
            end
            `I2CAF_MASK_OFF: begin
               slave_address_mask_reg <= pwdata[9:0];
            end
            `I2CAF_BAUD_OFF: begin
               baud_reload_reg <= pwdata[BRG_WIDTH-1:0];
            end
            default: begin
               bus_control_reg <= bus_control_reg;
            end
         endcase
      end
   end

   // Read data captured in setup so it is stable for the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (rd_en) begin
            case (paddr)
               `I2CAF_CTRL_OFF: prdata <= bus_control_reg;
               `I2CAF_ADDR_OFF: prdata <= {22'h000000, slave_addr_reg};
               `I2CAF_MASK_OFF: prdata <= {22'h000000, slave_address_mask_reg};
               `I2CAF_BAUD_OFF: prdata <= {{(32-BRG_WIDTH){1'b0}}, baud_reload_reg};
               `I2CAF_STAT_OFF: prdata <= {28'h0000000, scl_out, st_upper, st_gcall, st_match};
               `I2CAF_RXA_OFF: prdata <= {24'h000000, last_byte};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   i2caf_baud #(
      .WIDTH(BRG_WIDTH)
   ) u_baud (
      .pclk(pclk),
      .presetn(presetn),
      .run(bus_control_reg[`I2CAF_CTRL_EN] && bus_control_reg[`I2CAF_CTRL_MASTER]),
      .reload(baud_reload_reg),
      .scl_level(scl_level)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_out <= 1'b1;
      end else begin
         scl_out <= scl_level;
      end
   end
endmodule

// ---- i2caf_chk_assertions.sv ----
// Port checker for the address filter and serial clock.
// Assumes a bind onto i2caf_top.
`timescale 1ns/1ps
module i2caf_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Filter
   input wire logic addr_valid,
   input wire logic [7:0] addr_byte,
   input wire logic addr_second,
   input wire logic addr_ack,
   input wire logic addr_nack,
   // Serial clock
   input wire logic scl_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic pend, up_b, up_ok;
   wire first = addr_valid && !addr_second;
   // Outcome of the last upper byte, for the second byte
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 1'b0;
         up_b <= 1'b0;
         up_ok <= 1'b0;
      end else begin
         pend <= first;
         up_b <= addr_byte[7:3] == 5'h1E;
         if (pend)
            up_ok <= up_b && addr_ack;
      end
   end
   resv_low_a: assert property (
      first && addr_byte[7:4] == 4'h0 && addr_byte[7:1] != 7'h00 |=> addr_nack) else $error("reserved low acked");
   start_byte_a: assert property (
      first && addr_byte == 8'h01 |=> addr_nack) else $error("start byte acked");
   resv_high_a: assert property (
      first && addr_byte[7:3] == 5'h1F |=> addr_nack) else $error("reserved high acked");
   one_answer_a: assert property (
      addr_valid |=> addr_ack != addr_nack) else $error("no single answer");
   answer_cause_a: assert property (
      addr_ack || addr_nack |-> $past(addr_valid)) else $error("answer without byte");
   ack_excl_a: assert property (
      !(addr_ack && addr_nack)) else $error("ack and nack together");
   second_alone_a: assert property (
      addr_valid && addr_second && !(up_ok || pend && up_b && addr_ack) |=> addr_nack) else $error("lone low acked");
   scl_half_a: assert property (
      $changed(scl_out) |=> $stable(scl_out)) else $error("serial clock half too short");
   cover property (addr_valid ##1 addr_ack);
   cover property (addr_valid && addr_second ##1 addr_ack);
   cover property ($fell(scl_out));
endmodule

// ---- i2caf_peer.sv ----
// Far-side bus model: presents received address bytes, collects answers.
// Assumes the filter answers one cycle after each byte.
`timescale 1ns/1ps
module i2caf_peer (
   // Clock
   input wire logic pclk,
   // Answer
   input wire logic addr_ack,
   input wire logic addr_nack,
   // Byte
   output logic addr_valid = 1'b0,
   output logic [7:0] addr_byte = 8'h00,
   output logic addr_second = 1'b0
);
   task send(input logic [7:0] b, input logic s, output logic [1:0] r);
      @(posedge pclk);
      addr_valid <= 1'b1;
      addr_byte <= b;
      addr_second <= s;
      @(posedge pclk);
      addr_valid <= 1'b0;
      // Stale byte inverted so nothing leans on it
      addr_byte <= ~b;
      @(negedge pclk);
      r = {addr_ack, addr_nack};
   endtask
endmodule

// ---- testbench.sv ----
// Bench: APB set-up, address filter outcomes, serial clock high half-periods.
// Assumes the peer model feeds address bytes.
`timescale 1ns/1ps
`include "i2caf_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, addr_valid, addr_second, addr_ack, addr_nack, scl_out;
   logic [7:0] addr_byte;
   logic [1:0] res;
   logic perr;
   int err_total = 0, n_compared = 0, n;
   always #2.5 pclk = ~pclk;
   i2caf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .addr_valid(addr_valid), .addr_byte(addr_byte), .addr_second(addr_second),
      .addr_ack(addr_ack), .addr_nack(addr_nack), .scl_out(scl_out));
   i2caf_peer peer (.pclk(pclk), .addr_ack(addr_ack), .addr_nack(addr_nack),
      .addr_valid(addr_valid), .addr_byte(addr_byte), .addr_second(addr_second));
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk_wait(input int cnt);
      if (cnt >= 100) begin
         err_total++;
         print_verdict;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      chk_wait(n);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task flt(input logic [7:0] b, input logic s, input logic e);
      peer.send(b, s, res);
      `CHK(res, e ? 2'b10 : 2'b01)
   endtask
   task half(input logic [8:0] r);
      apb(1, `I2CAF_BAUD_OFF, r);
      apb(1, `I2CAF_CTRL_OFF, 32'h3);
      for (int v = 0; v < 2; v++) begin
         n = 0;
         while (scl_out !== v[0] && n < 100) begin
            @(negedge pclk);
            n++;
         end
         chk_wait(n);
      end
      n = 0;
      while (scl_out === 1'b1 && n < 100) begin
         @(negedge pclk);
         n++;
      end
      `CHK(n, 2 * (r + 1))
      apb(1, `I2CAF_CTRL_OFF, 32'h0);
   endtask
   logic [7:0] rsv [9] = '{8'h01, 8'h03, 8'h04, 8'h07, 8'h08, 8'h0F, 8'hF8, 8'hFF, 8'h00};
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1, `I2CAF_ADDR_OFF, 32'h50);
      apb(1, `I2CAF_CTRL_OFF, 32'h1);
      flt(8'hA0, 0, 1);
      flt(8'hA2, 0, 0);
      apb(1, `I2CAF_MASK_OFF, 32'h1);
      flt(8'hA2, 0, 1);
      apb(1, `I2CAF_CTRL_OFF, 32'h801);
      flt(8'hA2, 0, 0);
      apb(0, `I2CAF_CTRL_OFF, 32'h0);
      `CHK(rd, 32'h801)
      $display("mask test done");
      apb(1, `I2CAF_MASK_OFF, 32'h7F);
      apb(1, `I2CAF_CTRL_OFF, 32'h1);
      flt(8'hA4, 0, 1);
      foreach (rsv[i]) flt(rsv[i], 0, 0);
      flt(8'hF1, 0, 0);
      apb(1, `I2CAF_CTRL_OFF, 32'h81);
      flt(8'h00, 0, 1);
      apb(0, `I2CAF_STAT_OFF, 32'h0);
      `CHK(rd, 32'hB)
      flt(8'h01, 0, 0);
      apb(0, `I2CAF_RXA_OFF, 32'h0);
      `CHK(rd, 32'h1)
      `CHK(perr, 1'b0)
      $display("reserved test done");
      apb(1, `I2CAF_MASK_OFF, 32'h0);
      apb(1, `I2CAF_ADDR_OFF, 32'h2A5);
      apb(1, `I2CAF_CTRL_OFF, 32'h401);
      flt(8'hF4, 0, 1);
      apb(0, `I2CAF_STAT_OFF, 32'h0);
      `CHK(rd, 32'hD)
      flt(8'hA5, 1, 1);
      flt(8'hF6, 0, 0);
      flt(8'hA5, 1, 0);
      apb(1, `I2CAF_MASK_OFF, 32'h101);
      flt(8'hF6, 0, 1);
      flt(8'hA4, 1, 1);
      $display("ten-bit test done");
      half(9'd3);
      half(9'd0);
      $display("baud test done");
      print_verdict;
   end
endmodule
bind i2caf_top i2caf_chk chk (.pclk(pclk), .presetn(presetn), .addr_valid(addr_valid), .addr_byte(addr_byte),
   .addr_second(addr_second), .addr_ack(addr_ack), .addr_nack(addr_nack), .scl_out(scl_out));
